// ==== tcc_pkg.sv ====
// tcc_pkg: constants for the timer compare/capture register block.
// assumes every file refers to these names with an explicit tcc_pkg:: scope.
package tcc_pkg;

   // structure
   localparam int NUM_CH  = 5;                      // timer channels
   localparam int NUM_GR  = 10;                     // two general registers per channel
   localparam int NUM_SH  = 4;                      // shadow registers, channels 3 and 4
   localparam int SH_BASE = 6;                      // first general register with a shadow (a_ch3)
   localparam int IOC_W   = 3;                      // io control field width per register

   // register index on the cpu select port
   localparam logic [3:0] IDX_CC_A_CH0 = 4'h0;
   localparam logic [3:0] IDX_CC_B_CH0 = 4'h1;
   localparam logic [3:0] IDX_CC_A_CH1 = 4'h2;
   localparam logic [3:0] IDX_CC_B_CH1 = 4'h3;
   localparam logic [3:0] IDX_CC_A_CH2 = 4'h4;
   localparam logic [3:0] IDX_CC_B_CH2 = 4'h5;
   localparam logic [3:0] IDX_CC_A_CH3 = 4'h6;
   localparam logic [3:0] IDX_CC_B_CH3 = 4'h7;
   localparam logic [3:0] IDX_CC_A_CH4 = 4'h8;
   localparam logic [3:0] IDX_CC_B_CH4 = 4'h9;
   localparam logic [3:0] IDX_SH_A_CH3 = 4'ha;
   localparam logic [3:0] IDX_SH_B_CH3 = 4'hb;
   localparam logic [3:0] IDX_SH_A_CH4 = 4'hc;
   localparam logic [3:0] IDX_SH_B_CH4 = 4'hd;

   // reset values
   localparam logic [15:0] GR_RESET = 16'hffff;
   localparam logic [15:0] SH_RESET = 16'hffff;

   // io control field layout: bit 2 picks capture, bits 1:0 the action
   localparam int IOC_CAP_BIT = 2;
   localparam logic [1:0] OUT_NONE   = 2'h0;        // compare, no pin output
   localparam logic [1:0] OUT_LOW    = 2'h1;        // compare, drive 0 on match
   localparam logic [1:0] OUT_HIGH   = 2'h2;        // compare, drive 1 on match
   localparam logic [1:0] OUT_TOGGLE = 2'h3;        // compare, toggle on match
   localparam logic [1:0] CAP_RISE   = 2'h0;        // capture on rising edge
   localparam logic [1:0] CAP_FALL   = 2'h1;        // capture on falling edge; 1x is both edges

   // counter clear select
   localparam logic [1:0] CLR_NONE = 2'h0;
   localparam logic [1:0] CLR_BY_A = 2'h1;
   localparam logic [1:0] CLR_BY_B = 2'h2;

endpackage : tcc_pkg

// ==== tcc_regs.sv ====
// tcc_regs: compare/capture and shadow registers of a five channel 16-bit timer.
// assumes the counters, status register, io control and mode logic live outside
// and that all inputs are synchronous to clk.
//
// Summary of operation
// - ten 16-bit general registers, two per channel
// - io control picks compare or capture role
// - compare registers compared against counter continuously
// - counter match sets flag a or b
// - enabled compare output drives selected pin value
// - capture stores counter on external edge
// - capture sets flag a or b same cycle
// - only selected capture edges are accepted
// - pwm modes ignore io control setting
// - cpu word or byte access general registers
// - reset/standby: compare role, pin disabled
// - reset/standby loads general registers all ones
// - four 16-bit shadow registers, channels 3, 4
// - four separate shadow enable bits
// - shadow follows its pair's compare/capture role
// - buffered compare copies shadow on match
// - buffered capture moves old value to shadow
// - cpu word or byte access shadow registers
// - reset/standby loads shadow registers all ones
// - enable 0 normal, 1 buffered pair
// - clear select clears counter on a/b event
`timescale 1ns/10ps
module tcc_regs (
   // clock and reset
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   input  wire logic                       clk_en,
   input  wire logic                       standby,
   // cpu register port
   input  wire logic [3:0]                 cpu_sel,
   input  wire logic                       cpu_wr,
   input  wire logic                       cpu_rd,
   input  wire logic [1:0]                 cpu_be,
   input  wire logic [15:0]                cpu_wdata,
   output logic      [15:0]                cpu_rdata,
   // from the rest of the timer unit
   input  wire logic [16*tcc_pkg::NUM_CH-1:0]    chan_cnt,
   input  wire logic [tcc_pkg::IOC_W*tcc_pkg::NUM_GR-1:0] io_ctrl,
   input  wire logic [tcc_pkg::NUM_CH-1:0]       pwm_mode,
   input  wire logic [2*tcc_pkg::NUM_CH-1:0]     clear_sel,
   input  wire logic [tcc_pkg::NUM_SH-1:0]       shadow_en,
   // capture pins
   input  wire logic [tcc_pkg::NUM_GR-1:0]       capture_in,
   // compare pins and event outputs
   output logic      [tcc_pkg::NUM_GR-1:0]       cmp_out,
   output logic      [tcc_pkg::NUM_GR-1:0]       cmp_oe,
   output logic      [tcc_pkg::NUM_GR-1:0]       flag_set,
   output logic      [tcc_pkg::NUM_CH-1:0]       counter_clear
);

   logic [15:0] gr_val [tcc_pkg::NUM_GR];
   logic [15:0] sh_val [tcc_pkg::NUM_SH];
   logic [tcc_pkg::NUM_GR-1:0] ev;          // match or capture, combinational

   // one slice per general register; slices 6..9 also own a shadow register
   for (genvar i = 0; i < tcc_pkg::NUM_GR; i++) begin : g_gr
      localparam int CH = i / 2;
      localparam logic [3:0] SEL = 4'(i);
      logic [15:0] gr_q, gr_d;
      logic        eq_q, eq_d, cin_q, cin_d;
      logic        out_q, out_d, oe_q, oe_d, flag_q, flag_d;
      logic [2:0]  ioc;
      logic [15:0] cnt, wr_val, sh_cur;
      logic        cap_mode, match, rise, fall, cap_evt, buf_on;

      assign cnt = chan_cnt[CH*16 +: 16];
      // pwm modes own the pins, so io control falls back to plain compare
      assign ioc      = pwm_mode[CH] ? 3'h0 : io_ctrl[i*tcc_pkg::IOC_W +: tcc_pkg::IOC_W];
      assign cap_mode = ioc[tcc_pkg::IOC_CAP_BIT];
      // match fires once on the counter reaching the value, not every cycle it sits there
      assign match    = !cap_mode && (cnt == gr_q) && !eq_q;
      assign rise     = capture_in[i] && !cin_q;
      assign fall     = !capture_in[i] && cin_q;
      assign cap_evt  = cap_mode && (ioc[1] ? (rise || fall)
                                   : (ioc[1:0] == tcc_pkg::CAP_FALL) ? fall : rise);
      assign ev[i]    = match || cap_evt;
      assign wr_val   = {cpu_be[1] ? cpu_wdata[15:8] : gr_q[15:8],
                         cpu_be[0] ? cpu_wdata[7:0]  : gr_q[7:0]};

      if (i >= tcc_pkg::SH_BASE) begin : g_sh
         localparam int S = i - tcc_pkg::SH_BASE;
         localparam logic [3:0] SSEL = 4'(tcc_pkg::IDX_SH_A_CH3 + 4'(S));
         logic [15:0] sh_q, sh_d;
         assign buf_on = shadow_en[S];
         assign sh_cur = sh_q;

         // shadow: cpu write, overridden by the capture push
         always_comb begin
            sh_d = sh_q;
            if (standby) begin
               sh_d = tcc_pkg::SH_RESET;
            end else begin
               if (cpu_wr && cpu_sel == SSEL) begin
                  sh_d = {cpu_be[1] ? cpu_wdata[15:8] : sh_q[15:8],
                          cpu_be[0] ? cpu_wdata[7:0]  : sh_q[7:0]};
               end
               if (buf_on && cap_evt) begin
                  sh_d = gr_q;
               end
            end
         end

         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               sh_q <= tcc_pkg::SH_RESET;
            end else if (clk_en) begin
               sh_q <= sh_d;
            end
         end
         assign sh_val[S] = sh_q;
      end else begin : g_nosh
         assign buf_on = 1'b0;
         assign sh_cur = tcc_pkg::SH_RESET;
      end

      // general register, pin output and flag pulse
      always_comb begin
         gr_d   = gr_q;
         out_d  = out_q;
         oe_d   = 1'b0;
         flag_d = 1'b0;
         eq_d   = (cnt == gr_q);
         cin_d  = capture_in[i];
         if (standby) begin
            gr_d  = tcc_pkg::GR_RESET;
            out_d = 1'b0;
         end else begin
            if (cpu_wr && cpu_sel == SEL) begin
               gr_d = wr_val;
            end
            // hardware loads come last so they win over the cpu
            if (cap_evt) begin
               gr_d = cnt;
            end else if (match && buf_on) begin
               gr_d = sh_cur;
            end
            flag_d = match || cap_evt;
            oe_d   = !cap_mode && (ioc[1:0] != tcc_pkg::OUT_NONE);
            if (match) begin
               case (ioc[1:0])
                  tcc_pkg::OUT_LOW:    out_d = 1'b0;
                  tcc_pkg::OUT_HIGH:   out_d = 1'b1;
                  tcc_pkg::OUT_TOGGLE: out_d = !out_q;
                  default:             out_d = out_q;
               endcase
            end
         end
      end

      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            gr_q   <= tcc_pkg::GR_RESET;
            out_q  <= 1'b0;
            oe_q   <= 1'b0;
            flag_q <= 1'b0;
            eq_q   <= 1'b0;
            cin_q  <= 1'b0;
         end else if (clk_en) begin
            gr_q   <= gr_d;
            out_q  <= out_d;
            oe_q   <= oe_d;
            flag_q <= flag_d;
            eq_q   <= eq_d;
            cin_q  <= cin_d;
         end
      end

      assign gr_val[i]   = gr_q;
      assign cmp_out[i]  = out_q;
      assign cmp_oe[i]   = oe_q;
      assign flag_set[i] = flag_q;
   end

   // counter clear request per channel, from the selected register's event
   logic [tcc_pkg::NUM_CH-1:0] clr_q, clr_d;
   always_comb begin
      for (int c = 0; c < tcc_pkg::NUM_CH; c++) begin
         clr_d[c] = !standby &&
                    (((clear_sel[2*c +: 2] == tcc_pkg::CLR_BY_A) && ev[2*c]) ||
                     ((clear_sel[2*c +: 2] == tcc_pkg::CLR_BY_B) && ev[2*c+1]));
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         clr_q <= '0;
      end else if (clk_en) begin
         clr_q <= clr_d;
      end
   end
   assign counter_clear = clr_q;

   // read data, registered; unmapped indexes read zero
   logic [15:0] rd_q, rd_d;
   always_comb begin
      rd_d = rd_q;
      if (cpu_rd) begin
         if (cpu_sel < 4'(tcc_pkg::NUM_GR)) begin
            rd_d = gr_val[cpu_sel];
         end else if (cpu_sel >= tcc_pkg::IDX_SH_A_CH3 && cpu_sel <= tcc_pkg::IDX_SH_B_CH4) begin
            rd_d = sh_val[2'(cpu_sel - tcc_pkg::IDX_SH_A_CH3)];
         end else begin
            rd_d = 16'h0000;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_q <= 16'h0000;
      end else if (clk_en) begin
         rd_q <= rd_d;
      end
   end
   assign cpu_rdata = rd_q;

endmodule : tcc_regs

// ==== tcc_regs_checker.sv ====
// tcc_regs_checker: port-level assertions for the compare/capture register block.
// assumes it is bound to tcc_regs and that all inputs are synchronous to clk.
`timescale 1ns/10ps
module tcc_regs_checker (
   // clock and reset
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        clk_en,
   input wire logic        standby,
   // cpu read side
   input wire logic        cpu_rd,
   input wire logic [3:0]  cpu_sel,
   input wire logic [15:0] cpu_rdata,
   // timer side
   input wire logic [29:0] io_ctrl,
   input wire logic [4:0]  pwm_mode,
   input wire logic [9:0]  clear_sel,
   input wire logic [9:0]  capture_in,
   input wire logic [9:0]  cmp_out,
   input wire logic [9:0]  cmp_oe,
   input wire logic [9:0]  flag_set,
   input wire logic [4:0]  counter_clear
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // pins and events of channel 0 are watched, and of all ten registers in standby; the others share the same logic
   standby_quiet_a: assert property (clk_en && standby |=> cmp_oe == 10'h0 && flag_set == 10'h0)
      else $error("pin enable or flag active after standby");
   oe_drive_a: assert property (clk_en && !standby && !pwm_mode[0] && io_ctrl[2:0] == 3'h2 |=> cmp_oe[0])
      else $error("compare pin not enabled");
   pwm_ignore_a: assert property (clk_en && !standby && pwm_mode[0] |=> cmp_oe[1:0] == 2'h0)
      else $error("pin enabled in pwm mode");
   match_drive_a: assert property (flag_set[0] && $past(io_ctrl[2:0]) == 3'h2 && !$past(pwm_mode[0]) |-> cmp_out[0])
      else $error("match did not drive pin high");
   // history across reset or standby is not trusted, so those edges are skipped
   rise_capture_a: assert property (clk_en && $past(clk_en) && $past(rst_n) && !$past(standby) && !standby
      && !pwm_mode[0] && io_ctrl[5:3] == 3'h4 && $rose(capture_in[1]) |=> flag_set[1])
      else $error("rising capture edge missed");
   fall_ignore_a: assert property (!pwm_mode[0] && io_ctrl[5:3] == 3'h4 && $fell(capture_in[1]) |=> !flag_set[1])
      else $error("falling edge captured in rise mode");
   clear_by_a_a: assert property (flag_set[0] && $past(clear_sel[1:0]) == 2'h1 |-> counter_clear[0])
      else $error("counter clear missing on event a");
   clear_cause_a: assert property (counter_clear[0] |-> flag_set[1:0] != 2'h0)
      else $error("counter clear without event");
   unmapped_zero_a: assert property (clk_en && cpu_rd && cpu_sel == 4'he |=> cpu_rdata == 16'h0)
      else $error("unmapped read not zero");
   rdata_hold_a: assert property (!(clk_en && cpu_rd) |=> $stable(cpu_rdata))
      else $error("read data changed without read");
endmodule : tcc_regs_checker

bind tcc_regs tcc_regs_checker u_chk (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .standby(standby),
   .cpu_rd(cpu_rd), .cpu_sel(cpu_sel), .cpu_rdata(cpu_rdata), .io_ctrl(io_ctrl), .pwm_mode(pwm_mode),
   .clear_sel(clear_sel), .capture_in(capture_in), .cmp_out(cmp_out), .cmp_oe(cmp_oe),
   .flag_set(flag_set), .counter_clear(counter_clear));

// ==== tcc_regs_bench.sv ====
// tcc_regs_bench: directed scenarios for the compare/capture register block.
// assumes a 50 MHz clock and the register index map of tcc_pkg.
`timescale 1ns/10ps
module tcc_regs_bench;
   logic        clk, rst_n, clk_en, standby, cpu_wr, cpu_rd;
   logic [3:0]  cpu_sel, shadow_en;
   logic [1:0]  cpu_be;
   logic [15:0] cpu_wdata, cpu_rdata;
   logic [79:0] chan_cnt;
   logic [29:0] io_ctrl;
   logic [4:0]  pwm_mode, counter_clear;
   logic [9:0]  clear_sel, capture_in, cmp_out, cmp_oe, flag_set;
   int          n_fail, n_compared, cycles;

   // clk_en is driven so that the freeze behaviour is exercised as well
   tcc_regs u_dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .standby(standby), .cpu_sel(cpu_sel),
      .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_be(cpu_be), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
      .chan_cnt(chan_cnt), .io_ctrl(io_ctrl), .pwm_mode(pwm_mode), .clear_sel(clear_sel),
      .shadow_en(shadow_en), .capture_in(capture_in), .cmp_out(cmp_out), .cmp_oe(cmp_oe),
      .flag_set(flag_set), .counter_clear(counter_clear));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // inputs always move 1 ns after the edge so no race with the design's flops
   task automatic step();
      @(posedge clk);
      #1;
   endtask : step

   task automatic chk_pin(input string what, input logic exp, input logic got);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %b seen %b", what, exp, got);
      end
   endtask : chk_pin

   task automatic wr(input logic [3:0] sel, input logic [1:0] be, input logic [15:0] d);
      cpu_sel = sel;
      cpu_be = be;
      cpu_wdata = d;
      cpu_wr = 1'b1;
      step();
      cpu_wr = 1'b0;
      // one idle edge so the next strobe never toggles in the same time step
      step();
   endtask : wr

   // read data is registered, so it is judged one edge after the strobe
   task automatic rd_chk(input logic [3:0] sel, input logic [15:0] exp);
      cpu_sel = sel;
      cpu_rd = 1'b1;
      step();
      cpu_rd = 1'b0;
      n_compared++;
      if (cpu_rdata !== exp) begin
         n_fail++;
         $display("MISMATCH register %0d expected %h seen %h", sel, exp, cpu_rdata);
      end
      step();
   endtask : rd_chk

   task automatic t_reset_and_access();
      rd_chk(4'h0, 16'hffff);
      rd_chk(4'hd, 16'hffff);
      rd_chk(4'he, 16'h0000);
      wr(4'h2, 2'h3, 16'h1234);
      rd_chk(4'h2, 16'h1234);
      wr(4'h2, 2'h1, 16'habcd);
      rd_chk(4'h2, 16'h12cd);
      wr(4'hb, 2'h2, 16'h5a00);
      rd_chk(4'hb, 16'h5aff);
   endtask : t_reset_and_access

   task automatic t_compare();
      io_ctrl[2:0] = 3'h2;
      clear_sel[1:0] = 2'h1;
      wr(4'h0, 2'h3, 16'h0005);
      chan_cnt[15:0] = 16'h0005;
      step();
      chk_pin("flag_a_ch0", 1'b1, flag_set[0]);
      chk_pin("pin_a_ch0", 1'b1, cmp_out[0]);
      chk_pin("pin_en_ch0", 1'b1, cmp_oe[0]);
      chk_pin("clear_ch0", 1'b1, counter_clear[0]);
      step();
      chk_pin("flag_a_ch0 end", 1'b0, flag_set[0]);
      pwm_mode[0] = 1'b1;
      step();
      step();
      chk_pin("pin_en_pwm", 1'b0, cmp_oe[0]);
      pwm_mode[0] = 1'b0;
      // a write while the clock enable is low must leave the register untouched
      clk_en = 1'b0;
      wr(4'h0, 2'h3, 16'h7777);
      clk_en = 1'b1;
      rd_chk(4'h0, 16'h0005);
   endtask : t_compare

   task automatic t_capture();
      io_ctrl[5:3] = 3'h4;
      chan_cnt[15:0] = 16'h0abc;
      capture_in[1] = 1'b1;
      step();
      chk_pin("flag_b_ch0", 1'b1, flag_set[1]);
      capture_in[1] = 1'b0;
      chan_cnt[15:0] = 16'h0def;
      step();
      chk_pin("flag_b_ch0 fall", 1'b0, flag_set[1]);
      rd_chk(4'h1, 16'h0abc);
   endtask : t_capture

   task automatic t_shadow();
      shadow_en[1:0] = 2'h3;
      io_ctrl[23:21] = 3'h4;
      wr(4'ha, 2'h3, 16'h0020);
      wr(4'h6, 2'h3, 16'h0010);
      wr(4'h7, 2'h3, 16'h1111);
      chan_cnt[63:48] = 16'h0010;
      capture_in[7] = 1'b1;
      step();
      step();
      rd_chk(4'h6, 16'h0020);
      rd_chk(4'h7, 16'h0010);
      rd_chk(4'hb, 16'h1111);
   endtask : t_shadow

   task automatic t_standby();
      standby = 1'b1;
      step();
      standby = 1'b0;
      rd_chk(4'h6, 16'hffff);
      rd_chk(4'ha, 16'hffff);
   endtask : t_standby

   task automatic complete_run();
      if (n_fail == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : complete_run

   // the scenarios need a few dozen cycles; the ceiling leaves ample margin
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         n_fail++;
         complete_run();
      end
   end

   initial begin
      {rst_n, standby, cpu_wr, cpu_rd, cpu_sel, cpu_be, cpu_wdata} = '0;
      {chan_cnt, io_ctrl, pwm_mode, clear_sel, shadow_en, capture_in} = '0;
      clk_en = 1'b1;
      repeat (3) @(posedge clk);
      #1 rst_n = 1'b1;
      t_reset_and_access();
      t_compare();
      t_capture();
      t_shadow();
      t_standby();
      complete_run();
   end
endmodule : tcc_regs_bench
